// ### gpio_pkg.sv
package gpio_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [15:0] bidir_port_data_addr      = 16'hffdc;
  localparam logic [15:0] input_port_levels_addr    = 16'hffdd;
  localparam logic [15:0] bidir_port_direction_addr = 16'hffec;
  localparam logic [15:0] addr_mask                 = 16'hffff;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned bidir_width  = 5;
  localparam int unsigned input_width  = 8;
  localparam int unsigned chan_width   = 4;
  localparam logic [7:0]  data_reset   = 8'hc0;
  localparam logic [7:0]  dir_reset    = 8'hc0;
  localparam logic [7:0]  dir_readback = 8'hff;
  localparam logic [1:0]  data_top_ones = 2'h3;
  localparam logic        data_bit5    = 1'b0;

  // ****************************************
  // power modes
  // ****************************************
  typedef enum logic [2:0] {
    mode_run   = 3'h1,
    mode_hold  = 3'h2,
    mode_hiz   = 3'h4
  } pin_mode_t;

  typedef struct packed {
    logic [bidir_width-1:0] out;
    logic [bidir_width-1:0] oe_n;
  } bidir_drive_t;

  localparam logic [1:0] htrans_nonseq = 2'h2;

endpackage

// ### gpio_bidir_bit.sv
`timescale 1ns/1ps
module gpio_bidir_bit
  import gpio_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       dir,
  input  wire logic       latch,
  input  wire logic       pin_in,
  input  wire pin_mode_t  mode,
  output logic            pin_out,
  output logic            pin_oe_n,
  output logic            rd_bit
);

  logic drive_d;

  assign drive_d = dir & (mode == mode_run);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (mode != mode_hold) begin
      pin_out  <= latch;
      pin_oe_n <= ~drive_d;
    end
  end

  assign rd_bit = dir ? latch : pin_in;

endmodule

// ### gpio_port9b.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module gpio_port9b
  import gpio_pkg::*;
#(
  parameter bit flash_variant = 1'b0
)
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [bidir_width-1:0] bidir_pin_in,
  output logic      [bidir_width-1:0] bidir_pin_out,
  output logic      [bidir_width-1:0] bidir_pin_oe_n,
  input  wire logic [input_width-1:0] input_pin,
  input  wire logic                   analog_select_valid,
  input  wire logic [chan_width-1:0]  converter_channel_select,
  input  wire pin_mode_t              power_mode
);
  import gpio_pkg::*;

  // ****************************************
  // bus address phase capture
  // ****************************************
  logic        wr_pend_q;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic [7:0]  dir_q;
  logic [31:0] hrdata_q;
  logic [7:0]  data_d;
  logic [7:0]  dir_d;

  wire        req_valid = hsel & hready & htrans[1];
  wire [15:0] req_addr  = haddr[15:0] & addr_mask;
  wire        hit_data  = wr_pend_q & (addr_q == bidir_port_data_addr);
  wire        hit_dir   = wr_pend_q & (addr_q == bidir_port_direction_addr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 16'h0000;
    end else begin
      wr_pend_q <= req_valid & hwrite;
      addr_q    <= req_addr;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  wire [4:0] wr_bits = hwdata[4:0] & {4'hf, ~flash_variant};

  assign data_d = hit_data ? {data_top_ones, data_bit5, wr_bits} : data_q;
  assign dir_d  = hit_dir ? {data_top_ones, 1'b0, hwdata[4:0]} : dir_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_q <= data_reset;
      dir_q  <= dir_reset;
    end else begin
      data_q <= data_d;
      dir_q  <= dir_d;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic [bidir_width-1:0] rd_bits;

  genvar i;
  generate
    for (i = 0; i < bidir_width; i++) begin : g_bit
      gpio_bidir_bit u_bit (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .dir      (dir_q[i] & ~(flash_variant && i == 0)),
        .latch    (data_q[i]),
        .pin_in   (bidir_pin_in[i]),
        .mode     (power_mode),
        .pin_out  (bidir_pin_out[i]),
        .pin_oe_n (bidir_pin_oe_n[i]),
        .rd_bit   (rd_bits[i])
      );
    end
  endgenerate

  // ****************************************
  // read path
  // ****************************************
  logic [input_width-1:0] chan_mask;
  always_comb begin
    chan_mask = '0;
    if (analog_select_valid && converter_channel_select < chan_width'(input_width))
      chan_mask[converter_channel_select[2:0]] = 1'b1;
  end

  wire [4:0] bidir_rd = {rd_bits[4:1], rd_bits[0] & ~flash_variant};
  wire [7:0] port_rd  = {data_top_ones, data_bit5, bidir_rd};
  wire [7:0] in_rd    = input_pin & ~chan_mask;
  wire       rd_req   = req_valid & ~hwrite;

  // ****************************************
  // read address decode
  // ****************************************
  logic [7:0] rd_sel;
  logic       rd_mapped;

  always_comb begin
    rd_sel    = 8'h00;
    rd_mapped = 1'b1;
    if (req_addr == bidir_port_data_addr) begin
      rd_sel = port_rd;
    end else if (req_addr == input_port_levels_addr) begin
      rd_sel = in_rd;
    end else if (req_addr == bidir_port_direction_addr) begin
      rd_sel = dir_readback;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_req) begin
      hrdata_q <= {24'h000000, rd_sel};
    end
  end

  // ****************************************
  // bus response
  // ****************************************
  logic hreadyout_q;
  logic hresp_q;

  // zero wait states and always okay, both held in flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  // input-only pins have no output driver at all

  // ****************************************
  // checks
  // ****************************************
  a_data_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    data_q[7:5] == 3'h6) else $error("reserved data bits changed");
  a_dir_rdback: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && req_addr == bidir_port_direction_addr |=> hrdata[7:0] == 8'hff)
    else $error("direction read not all ones");
  a_write_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    hit_data |=> data_q[4:1] == $past(hwdata[4:1])) else $error("data not latched");
  a_out_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    power_mode == mode_run && $stable(power_mode) && $stable(dir_q) && dir_q[1] |=>
    !bidir_pin_oe_n[1]) else $error("output pin not driven");
  a_hiz_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    power_mode == mode_hiz |=> &bidir_pin_oe_n) else $error("pins driven in standby");
  a_chan_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && req_addr == input_port_levels_addr && analog_select_valid &&
    converter_channel_select == 4'h2 |=> hrdata[2] == 1'b0)
    else $error("selected channel not zero");
  a_hold_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    power_mode == mode_hold |=> $stable(bidir_pin_oe_n) && $stable(bidir_pin_out))
    else $error("pins changed in hold");
  a_input_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && req_addr == bidir_port_data_addr && !dir_q[3] |=>
    hrdata[3] == $past(bidir_pin_in[3])) else $error("input bit not pin level");

  // ****************************************
  // named sequences
  // ****************************************
  sequence s_read_req(logic [15:0] a);
    rd_req && req_addr == a;
  endsequence

  sequence s_run_output(int unsigned n);
    power_mode == mode_run && dir_q[n];
  endsequence

  sequence s_run_input(int unsigned n);
    power_mode == mode_run && !dir_q[n];
  endsequence

  // ****************************************
  // read path checks
  // ****************************************
  a_data_rd_top: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_req(bidir_port_data_addr) |=> hrdata[7:5] == 3'h6)
    else $error("reserved data bits read wrong");

  a_out_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_req(bidir_port_data_addr) ##0 dir_q[2] |=> hrdata[2] == $past(data_q[2]))
    else $error("output bit not latch value");

  a_levels_read: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_req(input_port_levels_addr) ##0 !analog_select_valid |=>
    hrdata[7:0] == $past(input_pin))
    else $error("input port not pin levels");

  a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && !rd_mapped |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");

  a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req |=> hrdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");

  // ****************************************
  // register checks
  // ****************************************
  a_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
    hit_dir |=> dir_q[4:0] == $past(hwdata[4:0]))
    else $error("direction not latched");

  a_dir_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    dir_q[7:5] == 3'h6)
    else $error("reserved direction bits changed");

  a_flash_bit0: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_variant |-> data_q[0] == 1'b0 && bidir_pin_oe_n[0])
    else $error("flash supply bit used");

  a_no_write_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    !hit_dir |=> $stable(dir_q))
    else $error("direction changed without write");

  // ****************************************
  // pin checks
  // ****************************************
  a_pin_value: assert property (@(posedge hclk) disable iff (!hresetn)
    s_run_output(0) |=> bidir_pin_out[0] == $past(data_q[0]))
    else $error("output pin not latch value");

  a_input_float: assert property (@(posedge hclk) disable iff (!hresetn)
    s_run_input(4) |=> bidir_pin_oe_n[4])
    else $error("input pin driven");

  a_out_drive4: assert property (@(posedge hclk) disable iff (!hresetn)
    s_run_output(4) |=> !bidir_pin_oe_n[4] && bidir_pin_out[4] == $past(data_q[4]))
    else $error("pin four not driven");

  // ****************************************
  // bus response checks
  // ****************************************
  a_always_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout == 1'b1)
    else $error("slave not ready");

  a_okay_resp: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0)
    else $error("response not okay");

endmodule

// ### pin_partner.sv
`timescale 1ns/1ps
module pin_partner
  import gpio_pkg::*;
(
  input  wire logic [bidir_width-1:0] ext_level,
  input  wire logic [bidir_width-1:0] pin_out,
  input  wire logic [bidir_width-1:0] pin_oe_n,
  output logic      [bidir_width-1:0] pin_level
);
  // ****
  // wire resolution
  // ****
  // a released pin shows the outside level
  always_comb begin
    for (int i = 0; i < bidir_width; i++) begin
      pin_level[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule

// ### tb_gpio_port9b.sv
`timescale 1ns/1ps
module tb_gpio_port9b;
  import gpio_pkg::*;
  logic        hclk = 0, hresetn = 0, hwrite = 0, valid = 0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, lfsr = 32'ha7f4ffd6;
  logic [1:0]  htrans = '0;
  logic [4:0]  ext = '0, pin_in, pin_out, oe_n;
  logic [7:0]  inp = '0, dir, dat, rv;
  logic [3:0]  ch = '0;
  pin_mode_t   pmode = mode_run;
  int          miscompares = 0, num_checks = 0;
  always #2 hclk = ~hclk;
  gpio_port9b gpio_port9b_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bidir_pin_in(pin_in),
    .bidir_pin_out(pin_out), .bidir_pin_oe_n(oe_n), .input_pin(inp),
    .analog_select_valid(valid), .converter_channel_select(ch), .power_mode(pmode));
  pin_partner pin_partner_i (.ext_level(ext), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_level(pin_in));
  // ****
  // expectations
  // ****
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_bidir(logic [7:0] d, logic [7:0] r, logic [4:0] e);
    return {3'b110, (d[4:0] & r[4:0]) | (~r[4:0] & e)};
  endfunction
  function automatic logic [7:0] exp_in(logic [7:0] p, logic v, logic [3:0] c);
    return (v && c < 4'h8) ? p & ~(8'h01 << c) : p;
  endfunction
  // ****
  // bus and checks
  // ****
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d, output logic [7:0] q);
    htrans <= htrans_nonseq;
    hwrite <= w;
    haddr <= {16'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("oe_n", 5'h1f, oe_n);
    chk("hresp", 10'h000, {9'h000, hresp});
    bus(0, bidir_port_data_addr, 0, rv);
    chk("data", 8'hc0, rv);
    bus(0, 16'hffde, 0, rv);
    chk("unmapped", 8'h00, rv);
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      dir = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : lfsr[7:0];
      dat = (i < 2) ? 8'hff : lfsr[15:8];
      ext <= lfsr[20:16];
      inp <= lfsr[31:24];
      valid <= lfsr[12];
      ch <= lfsr[23:20];
      bus(1, bidir_port_direction_addr, dir, rv);
      bus(1, bidir_port_data_addr, dat, rv);
      bus(0, bidir_port_direction_addr, 0, rv);
      chk("dir", 8'hff, rv);
      bus(0, bidir_port_data_addr, 0, rv);
      chk("data", exp_bidir(dat, dir, ext), rv);
      bus(1, input_port_levels_addr, ~inp, rv);
      bus(0, input_port_levels_addr, 0, rv);
      chk("levels", exp_in(inp, valid, ch), rv);
      chk("drive", {dir[4:0], dat[4:0] & dir[4:0]}, {~oe_n, pin_out & dir[4:0]});
    end
    pmode <= mode_hold;
    bus(1, bidir_port_data_addr, ~dat, rv);
    bus(1, bidir_port_direction_addr, 8'h00, rv);
    repeat (2) @(posedge hclk);
    chk("hold", {dir[4:0], dat[4:0] & dir[4:0]}, {~oe_n, pin_out & dir[4:0]});
    pmode <= mode_hiz;
    bus(1, bidir_port_direction_addr, 8'h1f, rv);
    repeat (2) @(posedge hclk);
    chk("standby", 5'h1f, oe_n);
    hresetn <= 1'b0;
    @(posedge hclk);
    pmode <= mode_run;
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("oe_n", 5'h1f, oe_n);
    bus(0, bidir_port_data_addr, 0, rv);
    chk("data", exp_bidir(8'hc0, 8'hc0, ext), rv);
    complete_run;
  end
endmodule
